// file: design/amc_pkg.sv
// Package: register layout, reset values and mode encodings for the converter control
package amc_pkg;
  localparam logic [19:0] AMC_MODE_CTRL_ADDR  = 20'hFFF30;
  localparam logic [7:0]  AMC_MODE_CTRL_RESET = 8'h00;
  localparam int          AMC_RUN_BIT         = 7;
  localparam int          AMC_CHMODE_BIT      = 6;
  localparam int          AMC_DIV_LSB         = 3;
  localparam int          AMC_VMODE_LSB       = 1;
  localparam int          AMC_CMP_BIT         = 0;
  localparam int          AMC_SCAN_CHANNELS   = 4;
  localparam int          AMC_SYNC_STAGES     = 2;

  // Trigger source modes, normally held in a neighbouring register
  typedef enum logic [1:0] {
    AMC_TRIG_SW      = 2'h0,
    AMC_TRIG_HW_NOWAIT = 2'h1,
    AMC_TRIG_HW_WAIT = 2'h2
  } amc_trig_e;

  typedef enum logic [1:0] {
    AMC_ST_STOP,
    AMC_ST_STANDBY,
    AMC_ST_CONVERT,
    AMC_ST_PROHIBITED
  } amc_opstate_e;

  // Peripheral clocks per conversion clock period for a divider code
  function automatic logic [6:0] amc_div_ratio(input logic [2:0] code);
    logic [6:0] r;
    r = 7'h02;
    unique case (code)
      3'h0: r = 7'h40;
      3'h1: r = 7'h20;
      3'h2: r = 7'h10;
      3'h3: r = 7'h08;
      3'h4: r = 7'h06;
      3'h5: r = 7'h05;
      3'h6: r = 7'h04;
      3'h7: r = 7'h02;
    endcase
    return r;
  endfunction : amc_div_ratio
endpackage : amc_pkg

// file: design/amc_trig_sync.sv
// Trigger synchroniser and rising-edge pulse former
module amc_trig_sync
  import amc_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic trig_in,
  output logic      trig_pulse
);
  typedef struct packed {
    logic [AMC_SYNC_STAGES-1:0] sync;
    logic                       last;
    logic                       pulse;
  } amc_sync_s;

  amc_sync_s st_reg;
  amc_sync_s st_next;

  always_comb begin
    st_next       = st_reg;
    st_next.sync  = {st_reg.sync[0], trig_in};
    // Only the second stage feeds the edge detector
    st_next.last  = st_reg.sync[1];
    st_next.pulse = st_reg.sync[1] & ~st_reg.last;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign trig_pulse = st_reg.pulse;

  chk_pulse_single : assert property (@(posedge sys_clk) disable iff (!rst_n)
    trig_pulse |=> !trig_pulse) else $error("trigger pulse longer than one cycle");
endmodule : amc_trig_sync

// file: design/amc_clk_div.sv
// Conversion clock divider producing a one-cycle tick per conversion clock
module amc_clk_div
  import amc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [2:0] div_code,
  output logic            conv_tick
);
  typedef struct packed {
    logic [6:0] cnt;
    logic       tick;
  } amc_div_s;

  amc_div_s st_reg;
  amc_div_s st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.tick = 1'b0;
    if (!run) begin
      // Preload one so the first tick lands within ratio-1 clocks of the start
      st_next.cnt = 7'h01;
    end else if (st_reg.cnt >= amc_div_ratio(div_code) - 7'h01) begin
      st_next.cnt  = 7'h00;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 7'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign conv_tick = st_reg.tick;

  chk_tick_idle : assert property (@(posedge sys_clk) disable iff (!rst_n)
    !run ##1 !run |-> !conv_tick) else $error("tick while divider stopped");
endmodule : amc_clk_div

// file: design/amc_mode_control.sv
// Converter mode and control register with run-flag sequencing
module amc_mode_control
  import amc_pkg::*;
#(
  parameter int CONV_CLOCKS = 12,
  parameter int STAB_CLOCKS = 4
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       converter_clock_gate,
  input  wire logic       reg_wr_byte,
  input  wire logic       reg_wr_bit,
  input  wire logic [2:0] reg_wr_bit_idx,
  input  wire logic [7:0] reg_wr_data,
  output logic      [7:0] reg_rd_data,
  input  wire logic [1:0] trig_mode,
  input  wire logic       one_shot,
  input  wire logic       hw_trig,
  output logic            conv_run_flag,
  output logic            channel_mode_sel,
  output logic      [2:0] clk_div_sel,
  output logic      [1:0] voltage_mode,
  output logic            comparator_enable,
  output logic            comparator_power,
  output logic            conv_active,
  output logic      [1:0] scan_channel,
  output logic            conv_tick,
  output logic            conversion_done_irq,
  output logic      [1:0] op_state
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic       busy;
    logic       waiting;
    logic [7:0] cyc;
    logic [1:0] chan;
    logic       irq;
  } amc_state_s;

  amc_state_s st_reg;
  amc_state_s st_next;
  logic       trig_pulse;
  logic       tick;
  logic [7:0] wr_val;
  logic       wr_any;
  logic       hw_mode;
  logic       wait_mode;
  logic       conv_end;

  amc_trig_sync u_sync (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .trig_in   (hw_trig),
    .trig_pulse(trig_pulse)
  );

  // Divider restarts each time busy rises, not between back-to-back conversions; its preload bounds the start latency
  amc_clk_div u_div (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .run      (st_reg.busy),
    .div_code (st_reg.ctrl[AMC_DIV_LSB +: 3]),
    .conv_tick(tick)
  );

  assign hw_mode   = (trig_mode != AMC_TRIG_SW);
  assign wait_mode = (trig_mode == AMC_TRIG_HW_WAIT);
  assign wr_any    = converter_clock_gate & (reg_wr_byte | reg_wr_bit);
  assign conv_end  = tick && st_reg.cyc == 8'(CONV_CLOCKS - 1);

  always_comb begin
    wr_val = st_reg.ctrl;
    if (reg_wr_byte) begin
      wr_val = reg_wr_data;
    end else if (reg_wr_bit) begin
      wr_val[reg_wr_bit_idx] = reg_wr_data[0];
    end
  end

  always_comb begin
    st_next     = st_reg;
    st_next.irq = 1'b0;
    if (wr_any) begin
      // Software writes 0 always stops; a 1 only counts outside wait mode
      st_next.ctrl = wr_val;
      if (wait_mode && !st_reg.ctrl[AMC_RUN_BIT]) begin
        st_next.ctrl[AMC_RUN_BIT] = 1'b0;
      end
    end
    // Idle wait mode with the comparator enabled takes every trigger not met by a write of 0 to the run bit, so sequential runs restart here too
    if (wait_mode && trig_pulse && st_reg.ctrl[AMC_CMP_BIT] && !st_reg.busy && !st_reg.waiting
        && !(wr_any && (reg_wr_byte || reg_wr_bit_idx == 3'(AMC_RUN_BIT))
             && !wr_val[AMC_RUN_BIT])) begin
      st_next.ctrl[AMC_RUN_BIT] = 1'b1;
      st_next.waiting           = 1'b1;
      st_next.cyc               = 8'h00;
    end
    // Run with no comparator is prohibited: no conversion takes place
    if (!st_next.ctrl[AMC_RUN_BIT] || !st_next.ctrl[AMC_CMP_BIT]) begin
      st_next.busy    = 1'b0;
      st_next.waiting = 1'b0;
      st_next.cyc     = 8'h00;
      st_next.chan    = 2'h0;
    end else if (st_reg.waiting) begin
      st_next.cyc = st_reg.cyc + 8'h01;
      if (st_reg.cyc == 8'(STAB_CLOCKS - 1)) begin
        st_next.waiting = 1'b0;
        st_next.busy    = 1'b1;
        st_next.cyc     = 8'h00;
      end
    end else if (!st_reg.busy && !st_reg.ctrl[AMC_RUN_BIT]) begin
      // Both hardware modes hold off until a trigger arrives
      st_next.busy = !hw_mode;
      st_next.cyc  = 8'h00;
    end else if (!st_reg.busy && !hw_mode) begin
      st_next.busy = 1'b1;
    end else if (hw_mode && !wait_mode && trig_pulse && !st_reg.busy) begin
      st_next.busy = 1'b1;
    end else if (st_reg.busy && tick) begin
      st_next.cyc = st_reg.cyc + 8'h01;
      if (conv_end) begin
        st_next.cyc = 8'h00;
        if (st_reg.ctrl[AMC_CHMODE_BIT] && st_reg.chan != 2'(AMC_SCAN_CHANNELS - 1)) begin
          st_next.chan = st_reg.chan + 2'h1;
        end else begin
          st_next.chan = 2'h0;
          st_next.irq  = 1'b1;
          if (one_shot && trig_mode != AMC_TRIG_HW_NOWAIT) begin
            st_next.ctrl[AMC_RUN_BIT] = 1'b0;
            st_next.busy              = 1'b0;
          end else if (hw_mode) begin
            st_next.busy = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg      <= '0;
      st_reg.ctrl <= AMC_MODE_CTRL_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  always_comb begin
    reg_rd_data = converter_clock_gate ? st_reg.ctrl : AMC_MODE_CTRL_RESET;
    op_state    = AMC_ST_STOP;
    unique case ({st_reg.ctrl[AMC_RUN_BIT], st_reg.ctrl[AMC_CMP_BIT]})
      2'b00: op_state = AMC_ST_STOP;
      2'b01: op_state = AMC_ST_STANDBY;
      2'b11: op_state = AMC_ST_CONVERT;
      2'b10: op_state = AMC_ST_PROHIBITED;
    endcase
  end

  assign conv_run_flag       = st_reg.ctrl[AMC_RUN_BIT];
  assign channel_mode_sel    = st_reg.ctrl[AMC_CHMODE_BIT];
  assign clk_div_sel         = st_reg.ctrl[AMC_DIV_LSB +: 3];
  assign voltage_mode        = st_reg.ctrl[AMC_VMODE_LSB +: 2];
  assign comparator_enable   = st_reg.ctrl[AMC_CMP_BIT];
  // Wait mode keeps the comparator dark until a trigger starts stabilisation
  assign comparator_power    = st_reg.ctrl[AMC_CMP_BIT]
                               & (!wait_mode | st_reg.busy | st_reg.waiting);
  assign conv_active         = st_reg.busy;
  assign scan_channel        = st_reg.chan;
  assign conv_tick           = tick;
  assign conversion_done_irq = st_reg.irq;

  chk_reset_zero : assert property (@(posedge sys_clk)
    $rose(rst_n) |-> reg_rd_data == 8'h00 || converter_clock_gate)
    else $error("register not zero after reset");
  chk_gate_ignore : assert property (@(posedge sys_clk) disable iff (!rst_n)
    !converter_clock_gate && !(wait_mode && trig_pulse) && !conv_end
    |=> $stable(st_reg.ctrl)) else $error("write taken with clock gate off");
  chk_gate_read : assert property (@(posedge sys_clk) disable iff (!rst_n)
    !converter_clock_gate |-> reg_rd_data == 8'h00) else $error("read not reset value");
  chk_byte_write : assert property (@(posedge sys_clk) disable iff (!rst_n)
    converter_clock_gate && reg_wr_byte && !wait_mode
    |=> st_reg.ctrl == $past(reg_wr_data)) else $error("byte write lost");
  chk_zero_clears : assert property (@(posedge sys_clk) disable iff (!rst_n)
    converter_clock_gate && reg_wr_byte && !reg_wr_data[7]
    |=> !conv_run_flag) else $error("write of 0 did not stop");
  chk_wait_trig : assert property (@(posedge sys_clk) disable iff (!rst_n)
    wait_mode && trig_pulse && comparator_enable && !conv_run_flag && !wr_any
    |=> conv_run_flag) else $error("trigger did not set run flag");
  chk_wait_power : assert property (@(posedge sys_clk) disable iff (!rst_n)
    wait_mode && !conv_run_flag |-> !comparator_power) else $error("comparator powered in standby");
  chk_nowait_hold : assert property (@(posedge sys_clk) disable iff (!rst_n)
    trig_mode == AMC_TRIG_HW_NOWAIT && conv_run_flag && !wr_any
    |=> conv_run_flag) else $error("run flag cleared by itself");
  chk_oneshot_clear : assert property (@(posedge sys_clk) disable iff (!rst_n)
    conversion_done_irq && one_shot && trig_mode != AMC_TRIG_HW_NOWAIT
    |-> !conv_run_flag) else $error("one-shot did not clear run flag");
  chk_start_bound : assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(conv_active) |-> ##[1:63] conv_tick) else $error("conversion start too late");

  // Register fields and write paths

  chk_bit_write : assert property (@(posedge sys_clk) disable iff (!rst_n)
    converter_clock_gate && reg_wr_bit && !reg_wr_byte && reg_wr_bit_idx != 3'(AMC_RUN_BIT)
    |=> st_reg.ctrl[$past(reg_wr_bit_idx)] == $past(reg_wr_data[0]))
    else $error("bit write lost");

  chk_field_hold : assert property (@(posedge sys_clk) disable iff (!rst_n)
    !wr_any |=> $stable(st_reg.ctrl[6:0]))
    else $error("setup field changed without a write");

  chk_select_chan : assert property (@(posedge sys_clk) disable iff (!rst_n)
    !channel_mode_sel |-> scan_channel == 2'h0)
    else $error("channel stepped in select mode");

  chk_sw_set : assert property (@(posedge sys_clk) disable iff (!rst_n)
    !wait_mode && !conv_run_flag && !wr_any |=> !conv_run_flag)
    else $error("run flag set without a write");

  chk_wait_no_set : assert property (@(posedge sys_clk) disable iff (!rst_n)
    wait_mode && !conv_run_flag && !trig_pulse |=> !conv_run_flag)
    else $error("run flag set in wait mode without trigger");

  // Conversion clock and start latency

  chk_tick_gap : assert property (@(posedge sys_clk) disable iff (!rst_n)
    conv_tick |=> !conv_tick)
    else $error("conversion clock tick too long");

  chk_tick_source : assert property (@(posedge sys_clk) disable iff (!rst_n)
    conv_tick |-> $past(conv_active))
    else $error("tick without a conversion");

  chk_nowait_start : assert property (@(posedge sys_clk) disable iff (!rst_n)
    trig_mode == AMC_TRIG_HW_NOWAIT && trig_pulse && conv_run_flag && comparator_enable
    && !conv_active && !st_reg.waiting && !wr_any |=> conv_active)
    else $error("no-wait trigger did not start conversion");

  chk_wait_begin : assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(st_reg.waiting) && conv_run_flag |-> conv_active)
    else $error("conversion did not follow stabilisation");

  // Run flag, comparator and operating state

  chk_run_stops : assert property (@(posedge sys_clk) disable iff (!rst_n)
    !conv_run_flag |-> !conv_active && !st_reg.waiting)
    else $error("activity with run flag clear");

  chk_wait_status : assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_reg.waiting |-> conv_run_flag && !conv_active)
    else $error("stabilisation wait not reported busy");

  chk_power_off : assert property (@(posedge sys_clk) disable iff (!rst_n)
    !comparator_enable |-> !comparator_power)
    else $error("comparator powered while disabled");

  chk_power_on : assert property (@(posedge sys_clk) disable iff (!rst_n)
    comparator_enable && !wait_mode |-> comparator_power)
    else $error("comparator dark while enabled");

  chk_prohibit_idle : assert property (@(posedge sys_clk) disable iff (!rst_n)
    op_state == AMC_ST_PROHIBITED |-> !conv_active)
    else $error("conversion in prohibited setting");

  chk_standby_idle : assert property (@(posedge sys_clk) disable iff (!rst_n)
    op_state == AMC_ST_STANDBY |-> !conv_active && !st_reg.waiting)
    else $error("conversion during standby");

  chk_stop_dark : assert property (@(posedge sys_clk) disable iff (!rst_n)
    op_state == AMC_ST_STOP |-> !comparator_power && !conv_active)
    else $error("activity during full stop");

  // Completion

  chk_scan_last : assert property (@(posedge sys_clk) disable iff (!rst_n)
    conversion_done_irq && channel_mode_sel |-> $past(scan_channel) == 2'(AMC_SCAN_CHANNELS - 1))
    else $error("scan ended before last channel");

  chk_irq_pulse : assert property (@(posedge sys_clk) disable iff (!rst_n)
    conversion_done_irq |=> !conversion_done_irq)
    else $error("done request longer than one cycle");

  chk_irq_source : assert property (@(posedge sys_clk) disable iff (!rst_n)
    conversion_done_irq |-> $past(conv_active))
    else $error("done request without a conversion");
endmodule : amc_mode_control

// file: verif/amc_trig_src.sv
// Hardware trigger source model driving the converter trigger input
module amc_trig_src (
  input  wire logic sys_clk,
  input  wire logic fire,
  output logic      hw_trig
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] hold_cnt = 3'h0;
  // Level held for five clocks so a two-stage synchroniser cannot miss it
  always @(posedge sys_clk) begin
    if (fire) begin
      hold_cnt <= 3'h5;
    end else if (hold_cnt != 3'h0) begin
      hold_cnt <= hold_cnt - 3'h1;
    end
  end
  assign hw_trig = (hold_cnt != 3'h0);
endmodule : amc_trig_src

// file: verif/tb.sv
// Self-checking bench for the converter mode and control register
module tb import amc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk = 1'b0;
  logic       rst_n, gate, wr_byte, wr_bit, one_shot, fire;
  logic [2:0] bit_idx, clk_div_sel;
  logic [7:0] wr_data, rd_data;
  logic [1:0] trig_mode, voltage_mode, scan_channel, op_state;
  logic       run_flag, chmode, cmp_en, cmp_pwr, conv_active, conv_tick, irq, hw_trig;
  int         num_errors = 0;
  int         samples_checked = 0;
  int         n;
  int         start_max [8] = '{63, 31, 15, 7, 5, 4, 3, 1};

  always #12.5 sys_clk = ~sys_clk;

  amc_mode_control #(.CONV_CLOCKS(2), .STAB_CLOCKS(2)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .converter_clock_gate(gate), .reg_wr_byte(wr_byte),
    .reg_wr_bit(wr_bit), .reg_wr_bit_idx(bit_idx), .reg_wr_data(wr_data),
    .reg_rd_data(rd_data), .trig_mode(trig_mode), .one_shot(one_shot), .hw_trig(hw_trig),
    .conv_run_flag(run_flag), .channel_mode_sel(chmode), .clk_div_sel(clk_div_sel),
    .voltage_mode(voltage_mode), .comparator_enable(cmp_en), .comparator_power(cmp_pwr),
    .conv_active(conv_active), .scan_channel(scan_channel), .conv_tick(conv_tick),
    .conversion_done_irq(irq), .op_state(op_state));

  amc_trig_src trig_src (.sys_clk(sys_clk), .fire(fire), .hw_trig(hw_trig));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] d);
    @(negedge sys_clk);
    wr_byte = 1'b1;
    wr_data = d;
    @(negedge sys_clk);
    wr_byte = 1'b0;
  endtask : wr

  task automatic wrb(input logic [2:0] i, input logic v);
    @(negedge sys_clk);
    wr_bit  = 1'b1;
    bit_idx = i;
    wr_data = {7'h00, v};
    @(negedge sys_clk);
    wr_bit = 1'b0;
  endtask : wrb

  // Comparator first, 40 clocks (1 us) settle, then run
  task automatic start(input logic [7:0] s);
    wr(s);
    repeat (40) @(negedge sys_clk);
    wr(s | 8'h80);
  endtask : start

  task automatic wait_irq;
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    check(irq, 1'b1);
  endtask : wait_irq

  task automatic pulse_trig;
    @(negedge sys_clk);
    fire = 1'b1;
    @(negedge sys_clk);
    fire = 1'b0;
  endtask : pulse_trig

  task automatic give_verdict;
    $display("errors %0d comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #(25 * 20000);
    num_errors++;
    give_verdict();
  end

  initial begin
    {rst_n, wr_byte, wr_bit, one_shot, fire, bit_idx, wr_data} = '0;
    gate      = 1'b1;
    trig_mode = AMC_TRIG_SW;
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    check(rd_data, 8'h00);
    check(op_state, 2'h0);
    gate = 1'b0;
    wr(8'h41);
    check(rd_data, 8'h00);
    gate = 1'b1;
    check(rd_data, 8'h00);
    wr(8'h01);
    check(op_state, 2'h1);
    check(cmp_pwr, 1'b1);
    wrb(3'h6, 1'b1);
    check(rd_data, 8'h41);
    check(chmode, 1'b1);
    wrb(3'h6, 1'b0);
    wr(8'h07);
    check(voltage_mode, 2'h3);
    gate = 1'b0;
    wr(8'h00);
    check(rd_data, 8'h00);
    gate = 1'b1;
    #1;
    check(rd_data, 8'h07);
    // Every divider code: start latency bound, then stop by writing 0
    for (int c = 0; c < 8; c++) begin
      start({2'h0, c[2:0], 3'h1});
      check(clk_div_sel, c[2:0]);
      check(rd_data[7], 1'b1);
      check(op_state, 2'h2);
      n = 0;
      while (conv_tick !== 1'b1 && n < 100) begin
        @(negedge sys_clk);
        n++;
      end
      check(n <= start_max[c], 1'b1);
      wr({2'h0, c[2:0], 3'h1});
      check(run_flag, 1'b0);
    end
    wr(8'h00);
    wr(8'h80);
    check(op_state, 2'h3);
    wr(8'h00);
    check(op_state, 2'h0);
    one_shot = 1'b1;
    start(8'h39);
    wait_irq();
    check(run_flag, 1'b0);
    start(8'h79);
    wait_irq();
    check(run_flag, 1'b0);
    trig_mode = AMC_TRIG_HW_NOWAIT;
    start(8'h39);
    pulse_trig();
    wait_irq();
    check(run_flag, 1'b1);
    wr(8'h39);
    check(run_flag, 1'b0);
    trig_mode = AMC_TRIG_HW_WAIT;
    #1;
    check(cmp_pwr, 1'b0);
    pulse_trig();
    n = 0;
    while (run_flag !== 1'b1 && n < 10) begin
      @(negedge sys_clk);
      n++;
    end
    check(run_flag, 1'b1);
    check(cmp_pwr, 1'b1);
    wait_irq();
    check(run_flag, 1'b0);
    give_verdict();
  end
endmodule : tb
